// [eeecsr_regs.sv]
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/10ps
module eeecsr_regs (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        wake_fault,
  input  wire logic        partner_lowpower_ability_in,
  output logic             local_lowpower_advertise,
  output logic             coding_sublayer_soft_reset,
  output logic             irq
);
  import eeecsr_pkg::*;

  // Pin synchronisers
  logic [1:0] fault_sync;
  logic [1:0] partner_sync;
  logic       fault_prev;
  logic       partner_ability;

  // Bus state
  eeecsr_phase_t phase;
  eeecsr_phase_t next_phase;
  logic          dp_write;
  logic [15:0]   dp_index;

  logic [15:0]          wake_fault_count;
  logic                 advertise;
  logic                 soft_reset;
  logic [irq_width-1:0] irq_status;
  logic [irq_width-1:0] irq_mask;

  wire        addr_take   = hsel & hready & htrans[1];
  wire [15:0] addr_index  = haddr[17:2];
  wire        wr_now      = (phase == eeecsr_data) & dp_write;
  wire        rd_now      = (phase == eeecsr_data) & ~dp_write;
  wire        fault_edge  = fault_sync[1] & ~fault_prev;
  wire        count_full  = (wake_fault_count == count_max);

  // Read data of the address phase being taken
  wire        hit_cap   = (addr_index == idx_capability_report);
  wire        hit_cnt   = (addr_index == idx_wake_fault_count);
  wire        hit_adv   = (addr_index == idx_local_advertise);
  wire        hit_lp    = (addr_index == idx_partner_ability);
  wire        hit_rst   = (addr_index == idx_soft_reset_ctrl);
  wire        hit_ist   = (addr_index == idx_irq_status);
  wire        hit_imk   = (addr_index == idx_irq_mask);
  wire [15:0] adv_word  = {14'h0000, advertise, 1'b0};
  wire [15:0] lp_word   = {14'h0000, partner_ability, 1'b0};
  wire [15:0] rd_word   = hit_cap ? capability_value :
                          hit_cnt ? wake_fault_count :
                          hit_adv ? adv_word :
                          hit_lp  ? lp_word :
                          hit_rst ? {soft_reset, 15'h0000} :
                          hit_ist ? {13'h0000, irq_status} :
                          hit_imk ? {13'h0000, irq_mask} :
                          16'h0000;
  wire        rd_take   = addr_take & ~hwrite;
  wire        clr_cnt   = rd_take & hit_cnt;
  wire        clr_ist   = rd_take & hit_ist;

  // Counter next value: clear, then add fault, saturate
  wire [15:0] base_cnt  = (clr_cnt | soft_reset) ? wake_fault_reset : wake_fault_count;
  wire        base_full = (base_cnt == count_max);
  wire [15:0] next_cnt  = (fault_edge & ~base_full) ? base_cnt + 16'h0001 :
                          base_cnt;

  wire [irq_width-1:0] irq_events = {partner_sync[1] ^ partner_ability,
                                     fault_edge & count_full,
                                     fault_edge};
  wire [irq_width-1:0] next_ist   = (clr_ist ? irq_reset : irq_status) | irq_events;

  // Bus phase: any taken address phase leads into a data phase
  always_comb begin
    next_phase = eeecsr_idle;
    case (phase)
      eeecsr_idle: begin
        if (addr_take) begin
          next_phase = eeecsr_data;
        end
      end
      eeecsr_data: begin
        if (addr_take) begin
          next_phase = eeecsr_data;
        end
      end
      default: begin
        next_phase = eeecsr_idle;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fault_sync   <= 2'b00;
      partner_sync <= 2'b00;
      fault_prev   <= 1'b0;
      partner_ability <= 1'b0;
    end else begin
      fault_sync   <= {fault_sync[0], wake_fault};
      partner_sync <= {partner_sync[0], partner_lowpower_ability_in};
      fault_prev   <= fault_sync[1];
      partner_ability <= partner_sync[1];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase    <= eeecsr_idle;
      dp_write <= 1'b0;
      dp_index <= 16'h0000;
      hrdata   <= 32'h0000_0000;
    end else if (addr_take) begin
      phase    <= next_phase;
      dp_write <= hwrite;
      dp_index <= addr_index;
      hrdata   <= {16'h0000, rd_word};
    end else begin
      phase    <= next_phase;
      dp_write <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_fault_count <= wake_fault_reset;
      advertise        <= advertise_reset[advertise_pos];
      soft_reset       <= 1'b0;
      irq_status       <= irq_reset;
      irq_mask         <= irq_reset;
    end else begin
      wake_fault_count <= next_cnt;
      irq_status       <= next_ist;
      if (soft_reset) begin
        advertise  <= advertise_reset[advertise_pos];
        soft_reset <= 1'b0;
      end else if (wr_now && dp_index == idx_soft_reset_ctrl) begin
        soft_reset <= hwdata[soft_reset_pos];
      end else if (wr_now && dp_index == idx_local_advertise) begin
        advertise  <= hwdata[advertise_pos];
      end
      if (wr_now && dp_index == idx_irq_mask) begin
        irq_mask <= hwdata[irq_width-1:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq                        <= 1'b0;
      local_lowpower_advertise   <= 1'b0;
      coding_sublayer_soft_reset <= 1'b0;
    end else begin
      irq                        <= |(next_ist & irq_mask);
      local_lowpower_advertise   <= advertise;
      coding_sublayer_soft_reset <= soft_reset;
    end
  end

  // Zero wait states and OKAY, both held in flops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  a_cnt_saturate: assert property (@(posedge hclk) disable iff (!hresetn)
    (count_full && !clr_cnt && !soft_reset) |=> count_full)
    else $error("fault counter wrapped");
  a_cnt_step: assert property (@(posedge hclk) disable iff (!hresetn)
    (!clr_cnt && !soft_reset && !count_full && fault_edge)
      |=> wake_fault_count == $past(wake_fault_count) + 16'h0001)
    else $error("counter did not add one");
  a_cnt_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    (!clr_cnt && !soft_reset && !fault_edge) |=> $stable(wake_fault_count))
    else $error("counter moved without fault");
  a_read_clears: assert property (@(posedge hclk) disable iff (!hresetn)
    (clr_cnt && !fault_edge) |=> wake_fault_count == 16'h0000 ##0
      hrdata[15:0] == $past(wake_fault_count))
    else $error("read did not return and clear");
  a_read_keeps_fault: assert property (@(posedge hclk) disable iff (!hresetn)
    (clr_cnt && fault_edge) |=> wake_fault_count == 16'h0001)
    else $error("fault lost during read");
  a_soft_clears: assert property (@(posedge hclk) disable iff (!hresetn)
    soft_reset |=> (!soft_reset && !advertise && wake_fault_count <= 16'h0001))
    else $error("soft reset failed");
  a_cap_value: assert property (@(posedge hclk) disable iff (!hresetn)
    (addr_take && hit_cap && !hwrite) |=> hrdata == 32'h0000_0002)
    else $error("capability word wrong");
  a_adv_write: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_now && dp_index == idx_local_advertise && !soft_reset)
      |=> ##1 local_lowpower_advertise == $past(hwdata[1], 2))
    else $error("advertise not applied");
  a_reserved_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    (addr_take && !hwrite && (hit_adv || hit_lp)) |=> hrdata[31:2] == 30'h0 && !hrdata[0])
    else $error("reserved bits nonzero");

  // Capability word
  a_cap_fast_bit: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_take && hit_cap) |=> hrdata[fast_lowpower_pos])
    else $error("fast low-power bit not set");
  a_cap_giga_bit: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_take && hit_cap) |=> !hrdata[gigabit_lowpower_pos])
    else $error("gigabit low-power bit set");
  a_cap_reserved: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_take && hit_cap) |=> (hrdata[31:3] == 29'h0 && !hrdata[0]))
    else $error("capability reserved bits set");

  // Fault counter
  a_read_returns: assert property (@(posedge hclk) disable iff (!hresetn)
    clr_cnt |=> hrdata[15:0] == $past(wake_fault_count))
    else $error("read returned wrong count");
  a_soft_count_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    (soft_reset && !fault_edge) |=> wake_fault_count == 16'h0000)
    else $error("soft reset left count");
  a_fault_edge_once: assert property (@(posedge hclk) disable iff (!hresetn)
    fault_edge |=> !fault_edge)
    else $error("one fault seen twice");
  a_cnt_no_drop: assert property (@(posedge hclk) disable iff (!hresetn)
    (!clr_cnt && !soft_reset) |=> wake_fault_count >= $past(wake_fault_count))
    else $error("count fell without clear");
  a_sat_status: assert property (@(posedge hclk) disable iff (!hresetn)
    (fault_edge && count_full) |=> irq_status[irq_saturate_pos])
    else $error("saturation event lost");

  // Soft reset output
  a_soft_pulse_out: assert property (@(posedge hclk) disable iff (!hresetn)
    soft_reset |=> coding_sublayer_soft_reset)
    else $error("soft reset not signalled");
  a_soft_out_once: assert property (@(posedge hclk) disable iff (!hresetn)
    coding_sublayer_soft_reset |=> !coding_sublayer_soft_reset)
    else $error("soft reset pulse too long");

  // Advertisement
  a_adv_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    (!soft_reset && !(wr_now && dp_index == idx_local_advertise))
      |=> $stable(advertise))
    else $error("advertise bit moved");
  a_adv_output: assert property (@(posedge hclk) disable iff (!hresetn)
    1'b1 |=> local_lowpower_advertise == $past(advertise))
    else $error("advertise output wrong");
  a_adv_read: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_take && hit_adv) |=> hrdata[advertise_pos] == $past(advertise))
    else $error("advertise readback wrong");

  // Partner ability
  a_partner_follow: assert property (@(posedge hclk) disable iff (!hresetn)
    1'b1 |=> partner_ability == $past(partner_sync[1]))
    else $error("partner bit not following pin");
  a_partner_read: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_take && hit_lp) |=> hrdata[partner_pos] == $past(partner_ability))
    else $error("partner readback wrong");
  a_partner_status: assert property (@(posedge hclk) disable iff (!hresetn)
    (partner_sync[1] != partner_ability) |=> irq_status[irq_partner_pos])
    else $error("partner change not flagged");

  // Reserved and unmapped bits
  a_unmapped_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_take && !(hit_cap || hit_cnt || hit_adv || hit_lp || hit_rst || hit_ist || hit_imk))
      |=> hrdata == 32'h0000_0000)
    else $error("unmapped read nonzero");
  a_upper_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    hrdata[31:16] == 16'h0000)
    else $error("upper read half nonzero");
  a_irq_reserved: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_take && (hit_ist || hit_imk)) |=> hrdata[31:3] == 29'h0)
    else $error("interrupt reserved bits set");

  // Interrupts
  a_fault_status: assert property (@(posedge hclk) disable iff (!hresetn)
    fault_edge |=> irq_status[irq_fault_pos])
    else $error("fault not flagged");
  a_status_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
    !clr_ist |=> (irq_status & $past(irq_status)) == $past(irq_status))
    else $error("status bit dropped");
  a_status_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    (clr_ist && irq_events == 3'h0) |=> irq_status == 3'h0)
    else $error("status not cleared by read");
  a_irq_level: assert property (@(posedge hclk) disable iff (!hresetn)
    $stable(irq_mask) |-> irq == |(irq_status & irq_mask))
    else $error("interrupt level wrong");
  a_mask_write: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_now && dp_index == idx_irq_mask) |=> irq_mask == $past(hwdata[irq_width-1:0]))
    else $error("mask write lost");

  c_fault_read: cover property (@(posedge hclk) disable iff (!hresetn)
    clr_cnt && fault_edge);
  c_saturated: cover property (@(posedge hclk) disable iff (!hresetn)
    count_full && fault_edge);
  c_soft_reset: cover property (@(posedge hclk) disable iff (!hresetn) soft_reset);
  c_adv_write: cover property (@(posedge hclk) disable iff (!hresetn)
    wr_now && dp_index == idx_local_advertise);
  c_partner_change: cover property (@(posedge hclk) disable iff (!hresetn)
    partner_sync[1] != partner_ability);
endmodule : eeecsr_regs

// [eeecsr_pkg.sv]
package eeecsr_pkg;
  // Register indices as printed; byte address is four times the index
  localparam logic [15:0] idx_capability_report = 16'h1014;
  localparam logic [15:0] idx_wake_fault_count  = 16'h1016;
  localparam logic [15:0] idx_local_advertise   = 16'h203c;
  localparam logic [15:0] idx_partner_ability   = 16'h203d;
  localparam logic [15:0] idx_soft_reset_ctrl   = 16'h1000;
  localparam logic [15:0] idx_irq_status        = 16'h1f00;
  localparam logic [15:0] idx_irq_mask          = 16'h1f01;
  // Field positions
  localparam int fast_lowpower_pos     = 1;
  localparam int gigabit_lowpower_pos  = 2;
  localparam int advertise_pos         = 1;
  localparam int partner_pos           = 1;
  localparam int soft_reset_pos        = 15;
  // Interrupt status bits
  localparam int irq_fault_pos         = 0;
  localparam int irq_saturate_pos      = 1;
  localparam int irq_partner_pos       = 2;
  localparam int irq_width             = 3;
  // Reset values, counter limit and capability word
  localparam logic [15:0] wake_fault_reset = 16'h0000;
  localparam logic [15:0] advertise_reset  = 16'h0000;
  localparam logic [2:0]  irq_reset        = 3'h0;
  localparam logic [15:0] count_max        = 16'hffff;
  localparam logic [15:0] capability_value = 16'h0002;
  typedef enum logic [1:0] {
    eeecsr_idle  = 2'b00,
    eeecsr_data  = 2'b01
  } eeecsr_phase_t;
endpackage : eeecsr_pkg

// [eeecsr_partner.sv]
`timescale 1ns/10ps
module eeecsr_partner (
  input  wire logic       hclk,
  input  wire logic       local_lowpower_advertise,
  input  wire logic       capable,
  input  wire logic [7:0] late_wakes,
  output logic            wake_fault,
  output logic            partner_lowpower_ability_in
);
  logic [7:0] sent;
  logic [2:0] phase;
  initial begin
    sent       = 8'h00;
    phase      = 3'h0;
    wake_fault = 1'b0;
  end
  // Each late wake is one fault pulse, four cycles high, four low
  always @(posedge hclk) begin
    phase <= phase + 3'h1;
    if (phase == 3'h0 && sent < late_wakes) begin
      wake_fault <= 1'b1;
      sent       <= sent + 8'h01;
    end else if (phase == 3'h4) begin
      wake_fault <= 1'b0;
    end
  end
  // Far end advertises 100BASE-TX low-power operation when capable
  assign partner_lowpower_ability_in = capable;
endmodule : eeecsr_partner

// [eeecsr_regs_tb_top.sv]
`timescale 1ns/10ps
module eeecsr_regs_tb_top;
  import eeecsr_pkg::*;
  logic hclk, hresetn, hsel, hwrite, capable, ready, irq, adv, fault, pab, resp, sreset_out;
  logic [31:0] haddr, hwdata, hrdata, scratch, total;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  late;
  int          n_fail, cmp_count, n_soft;
  eeecsr_regs uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(ready),
    .hrdata(hrdata), .hreadyout(ready), .hresp(resp), .wake_fault(fault),
    .partner_lowpower_ability_in(pab), .local_lowpower_advertise(adv),
    .coding_sublayer_soft_reset(sreset_out), .irq(irq));
  eeecsr_partner peer (.hclk(hclk), .local_lowpower_advertise(adv), .capable(capable),
    .late_wakes(late), .wake_fault(fault), .partner_lowpower_ability_in(pab));
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  // Soft reset pulses seen on the output
  always @(posedge hclk) begin
    if (sreset_out === 1'b1) n_soft++;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task xfer(input logic w, input logic [15:0] i, input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {14'h0000, i, 2'h0};
    do @(posedge hclk); while (ready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (ready !== 1'b1);
    scratch = hrdata;
  endtask : xfer
  task rd(input logic [15:0] i, input logic [31:0] exp);
    xfer(1'b0, i, 32'h0000_0000);
    chk(scratch, exp);
  endtask : rd
  task give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : give_verdict
  initial begin
    {hresetn, hsel, hwrite, capable} = 4'h0;
    {haddr, hwdata} = 64'h0;
    {htrans, hsize, late, n_fail, cmp_count} = 0;
    n_soft = 0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    hsize   <= 3'h2;
    rd(idx_capability_report, 16'h0002);
    xfer(1'b1, idx_capability_report, 32'hffff_ffff);
    rd(idx_capability_report, 16'h0002);
    rd(idx_local_advertise, 16'h0000);
    xfer(1'b1, idx_local_advertise, 32'hffff_ffff);
    rd(idx_local_advertise, 16'h0002);
    chk(adv, 1'b1);
    xfer(1'b1, 16'h0100, 32'hffff_ffff);
    rd(16'h0100, 16'h0000);
    chk(resp, 1'b0);
    $display("test registers done");
    capable <= 1'b1;
    repeat (6) @(posedge hclk);
    rd(idx_partner_ability, 16'h0002);
    capable <= 1'b0;
    repeat (6) @(posedge hclk);
    rd(idx_partner_ability, 16'h0000);
    $display("test partner done");
    xfer(1'b0, idx_irq_status, 32'h0000_0000);
    xfer(1'b1, idx_irq_mask, 32'h0000_0001);
    rd(idx_irq_mask, 16'h0001);
    late <= late + 8'h03;
    repeat (40) @(posedge hclk);
    chk(irq, 1'b1);
    rd(idx_wake_fault_count, 16'h0003);
    rd(idx_wake_fault_count, 16'h0000);
    rd(idx_irq_status, 16'h0001);
    repeat (2) @(posedge hclk);
    chk(irq, 1'b0);
    $display("test faults done");
    late <= late + 8'h02;
    repeat (40) @(posedge hclk);
    xfer(1'b1, idx_soft_reset_ctrl, 32'h0000_8000);
    rd(idx_soft_reset_ctrl, 16'h0000);
    rd(idx_wake_fault_count, 16'h0000);
    rd(idx_local_advertise, 16'h0000);
    chk(adv, 1'b0);
    chk(n_soft, 32'h0000_0001);
    $display("test soft reset done");
    late <= late + 8'h08;
    total = 32'h0000_0000;
    repeat (30) begin
      xfer(1'b0, idx_wake_fault_count, 32'h0000_0000);
      total = total + scratch;
    end
    chk(total, 32'h0000_0008);
    $display("test read during faults done");
    give_verdict();
  end
  initial begin
    repeat (3000) @(posedge hclk);
    n_fail++;
    give_verdict();
  end
endmodule : eeecsr_regs_tb_top
